// ===== wwt_pkg.sv
// constants for the windowed watchdog timer
package wwt_pkg;
	// ----------------------------------------------------------------
	// register map and key values
	// ----------------------------------------------------------------
	localparam logic [15:0] REFRESH_ADDR = 16'hFF99;
	localparam logic [7:0] REFRESH_KEY = 8'hAC;
	localparam logic [7:0] READ_VAL_EN = 8'h9A;
	localparam logic [7:0] READ_VAL_DIS = 8'h1A;
	// ----------------------------------------------------------------
	// option byte field positions
	// ----------------------------------------------------------------
	localparam int OPT_WIN_HI = 6;
	localparam int OPT_WIN_LO = 5;
	localparam int OPT_ENABLE = 4;
	localparam int OPT_OVF_HI = 3;
	localparam int OPT_OVF_LO = 1;
	localparam logic [7:0] OPT_RESET = 8'h00;
	// ----------------------------------------------------------------
	// counter timing
	// ----------------------------------------------------------------
	localparam int CNT_W = 17;
	localparam logic [16:0] PERIOD_MIN = 17'h00400;
	localparam logic [16:0] QUARTER_MIN = 17'h00100;
	// ----------------------------------------------------------------
	// addresses exempt from read and write checking; fetches are still checked
	// ----------------------------------------------------------------
	localparam logic [15:0] EXEMPT_A_LO = 16'hFB00;
	localparam logic [15:0] EXEMPT_A_HI = 16'hFFCF;
	localparam logic [15:0] EXEMPT_B_LO = 16'hFFE0;
	localparam logic [15:0] EXEMPT_B_HI = 16'hFFFF;
	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_INIT = 2'h0,
		ST_RUN = 2'h1,
		ST_FAULT = 2'h3
	} wwt_state_t;
endpackage

// ===== wwt_watchdog.sv
// windowed watchdog timer with refresh register and access checking
module wwt_watchdog #(
	parameter int CNT_W = wwt_pkg::CNT_W
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_lsclk,
	input wire logic [7:0] i_option_byte,
	input wire logic [15:0] i_mem_limit,
	input wire logic [15:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_bit_op,
	input wire logic i_fetch,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	output logic o_reset_req,
	output logic o_watchdog_reset_cause_flag
);
	// ----------------------------------------------------------------
	// parameter check
	// ----------------------------------------------------------------
	if (CNT_W != wwt_pkg::CNT_W) begin : g_bad_width
		$error("counter width must be 17");
	end

	wwt_pkg::wwt_state_t state_q;
	logic ls_s1_q, ls_s2_q, ls_s3_q;
	logic [7:0] opt_q;
	logic [16:0] cnt_q;
	logic first_q;
	logic pend_q;
	logic [7:0] rdata_q;
	logic tick;
	logic en;
	logic [2:0] ovf_sel;
	logic [1:0] win_sel;
	logic [1:0] mult;
	logic [16:0] term;
	logic [16:0] quarter;
	logic [16:0] thr;
	logic wr_hit, rd_hit;
	logic bit_fault, key_fault, win_fault, good_refresh;
	logic outside, exempt, mem_fault, ovf;

	// ----------------------------------------------------------------
	// low-speed clock synchroniser and edge detect
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ls_s1_q <= 1'b0;
			ls_s2_q <= 1'b0;
			ls_s3_q <= 1'b0;
		end else begin
			ls_s1_q <= i_lsclk;
			ls_s2_q <= ls_s1_q;
			ls_s3_q <= ls_s2_q;
		end
	end
	assign tick = ls_s2_q & ~ls_s3_q;

	// ----------------------------------------------------------------
	// option byte fields and window arithmetic
	// ----------------------------------------------------------------
	assign en = opt_q[wwt_pkg::OPT_ENABLE];
	assign ovf_sel = opt_q[wwt_pkg::OPT_OVF_HI:wwt_pkg::OPT_OVF_LO];
	assign win_sel = opt_q[wwt_pkg::OPT_WIN_HI:wwt_pkg::OPT_WIN_LO];
	assign term = (wwt_pkg::PERIOD_MIN << ovf_sel) - 17'h00001;
	assign quarter = wwt_pkg::QUARTER_MIN << ovf_sel;
	assign mult = 2'h3 - win_sel;
	assign thr = quarter * {15'h0000, mult};

	// ----------------------------------------------------------------
	// fault detection
	// ----------------------------------------------------------------
	assign wr_hit = (state_q == wwt_pkg::ST_RUN) && i_wr && (i_addr == wwt_pkg::REFRESH_ADDR);
	assign rd_hit = i_rd && (i_addr == wwt_pkg::REFRESH_ADDR);
	assign bit_fault = wr_hit && i_bit_op;
	assign key_fault = wr_hit && !i_bit_op && (i_wdata != wwt_pkg::REFRESH_KEY);
	assign win_fault = wr_hit && !i_bit_op && (i_wdata == wwt_pkg::REFRESH_KEY)
		&& en && !first_q && (cnt_q < thr);
	assign good_refresh = wr_hit && !i_bit_op && (i_wdata == wwt_pkg::REFRESH_KEY) && !win_fault;
	assign outside = i_addr >= i_mem_limit;
	assign exempt = ((i_addr >= wwt_pkg::EXEMPT_A_LO) && (i_addr <= wwt_pkg::EXEMPT_A_HI))
		|| ((i_addr >= wwt_pkg::EXEMPT_B_LO) && (i_addr <= wwt_pkg::EXEMPT_B_HI));
	assign mem_fault = en && (state_q == wwt_pkg::ST_RUN) && outside
		&& (i_fetch || ((i_rd || i_wr) && !exempt));
	assign ovf = en && (state_q == wwt_pkg::ST_RUN) && tick && (cnt_q == term) && !good_refresh;

	// ----------------------------------------------------------------
	// state: strap capture, run, fault
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= wwt_pkg::ST_INIT;
		end else begin
			case (state_q)
				wwt_pkg::ST_INIT: begin
					state_q <= wwt_pkg::ST_RUN;
				end
				wwt_pkg::ST_RUN: begin
					if (ovf || mem_fault || (pend_q && tick)) begin
						state_q <= wwt_pkg::ST_FAULT;
					end
				end
				wwt_pkg::ST_FAULT: begin
					state_q <= wwt_pkg::ST_FAULT;
				end
				default: begin
					state_q <= wwt_pkg::ST_INIT;
				end
			endcase
		end
	end

	// option byte caught once after reset release
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			opt_q <= wwt_pkg::OPT_RESET;
		end else if (state_q == wwt_pkg::ST_INIT) begin
			opt_q <= i_option_byte;
		end
	end

	// ----------------------------------------------------------------
	// counter and first-refresh flag
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_q <= 17'h00000;
		end else if (good_refresh) begin
			cnt_q <= 17'h00000;
		end else if (en && tick && (state_q == wwt_pkg::ST_RUN) && (cnt_q != term)) begin
			cnt_q <= cnt_q + 17'h00001;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			first_q <= 1'b1;
		end else if (wr_hit) begin
			first_q <= 1'b0;
		end
	end

	// illegal write held until the low-speed clock moves
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pend_q <= 1'b0;
		end else if (bit_fault || key_fault || win_fault) begin
			pend_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rdata_q <= 8'h00;
		end else if (rd_hit) begin
			rdata_q <= en ? wwt_pkg::READ_VAL_EN : wwt_pkg::READ_VAL_DIS;
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign o_rdata = rdata_q;
	assign o_reset_req = (state_q == wwt_pkg::ST_FAULT);
	assign o_watchdog_reset_cause_flag = (state_q == wwt_pkg::ST_FAULT);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);

	count_advance_a: assert property (
		(en && tick && !good_refresh && state_q == wwt_pkg::ST_RUN && cnt_q != term)
		|=> (cnt_q == $past(cnt_q) + 17'h00001))
		else $error("counter did not advance on tick");
	overflow_reset_a: assert property (ovf |=> o_reset_req)
		else $error("overflow did not request reset");
	bit_write_a: assert property (bit_fault |=> pend_q)
		else $error("bit write not caught");
	wrong_key_a: assert property (key_fault |=> pend_q)
		else $error("wrong key not caught");
	closed_window_a: assert property (
		(wr_hit && !i_bit_op && i_wdata == wwt_pkg::REFRESH_KEY && en && !first_q && cnt_q < thr)
		|=> pend_q)
		else $error("closed window write not caught");
	fetch_outside_a: assert property (
		(en && state_q == wwt_pkg::ST_RUN && i_fetch && i_addr >= i_mem_limit) |=> o_reset_req)
		else $error("outside fetch not caught");
	access_outside_a: assert property (
		(en && state_q == wwt_pkg::ST_RUN && i_rd && i_addr >= i_mem_limit && !exempt) |=> o_reset_req)
		else $error("outside access not caught");
	cause_flag_a: assert property (
		(state_q == wwt_pkg::ST_RUN && (ovf || mem_fault || (pend_q && tick))) |=> o_watchdog_reset_cause_flag)
		else $error("cause flag missing");
	refresh_clear_a: assert property (good_refresh |=> cnt_q == 17'h00000)
		else $error("refresh did not clear counter");
	read_value_a: assert property (
		rd_hit |=> (o_rdata == (en ? wwt_pkg::READ_VAL_EN : wwt_pkg::READ_VAL_DIS)))
		else $error("refresh read value wrong");
	deferred_reset_a: assert property (
		(pend_q && state_q == wwt_pkg::ST_RUN && !tick && !mem_fault && !ovf) |=> !o_reset_req)
		else $error("illegal write reset not deferred");
	auto_start_a: assert property ((state_q == wwt_pkg::ST_INIT) |=> (state_q == wwt_pkg::ST_RUN))
		else $error("counter did not start");

	refresh_ok_c: cover property (good_refresh && !first_q);
	overflow_c: cover property (ovf);
	deferred_c: cover property (pend_q && tick && state_q == wwt_pkg::ST_RUN);
	fetch_fault_c: cover property (mem_fault && i_fetch);
endmodule

// ===== wwt_cpu_model.sv
// cpu bus and low-speed oscillator model facing the watchdog
module wwt_cpu_model (
	input wire logic i_sys_clk,
	input wire logic i_ls_run,
	input wire logic [7:0] i_rdata,
	output logic o_lsclk,
	output logic [15:0] o_addr,
	output logic o_wr,
	output logic o_rd,
	output logic o_bit_op,
	output logic o_fetch,
	output logic [7:0] o_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] div_q = 3'h0;
	// ----------------------------------------
	// low-speed clock, still while stopped
	// ----------------------------------------
	assign o_lsclk = i_ls_run & div_q[2];
	always @(posedge i_sys_clk) begin
		if (i_ls_run) div_q <= div_q + 3'h1;
	end
	initial begin
		o_addr = 16'h0000;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_bit_op = 1'b0;
		o_fetch = 1'b0;
		o_wdata = 8'h00;
	end
	// ----------------------------------------
	// one access: kind 0 read, 1 write, 2 fetch
	// ----------------------------------------
	task automatic access(input logic [1:0] kind, input logic [15:0] addr, input logic [7:0] data,
		input logic bit_op, output logic [7:0] rdata);
		@(posedge i_sys_clk);
		#1;
		o_addr = addr;
		o_wdata = data;
		o_bit_op = bit_op; // whole-byte writes unless a bit write is asked
		o_wr = (kind == 2'h1);
		o_rd = (kind == 2'h0);
		o_fetch = (kind == 2'h2);
		@(posedge i_sys_clk);
		#1;
		rdata = i_rdata;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_fetch = 1'b0;
		o_bit_op = 1'b0;
		o_addr = ~addr;
		o_wdata = ~data;
	endtask
endmodule

// ===== tb_top.sv
// self-checking bench for the windowed watchdog
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [7:0] opt; int op; logic [15:0] addr; logic [7:0] data; logic [7:0] rd; logic req;} wwt_row_t;
	logic sys_clk, rstn, ls_run, lsclk, wr, rd, bit_op, fetch, req, flag;
	logic [7:0] opt, wdata, rdata, rd_got;
	logic [15:0] addr;
	logic [1:0] kind;
	int err_total = 0;
	int compares = 0;
	// op 0 read, 1 write, 2 fetch, 3 bit write, 4 key then write
	wwt_row_t rows [15] = '{
		'{8'h12, 0, 16'hFF99, 8'h00, 8'h9A, 1'b0}, '{8'h00, 0, 16'hFF99, 8'h00, 8'h1A, 1'b0},
		'{8'h12, 1, 16'hFF99, 8'hAC, 8'h00, 1'b0}, '{8'h12, 1, 16'hFF99, 8'h55, 8'h00, 1'b1},
		'{8'h12, 3, 16'hFF99, 8'hAC, 8'h00, 1'b1}, '{8'h12, 4, 16'hFF99, 8'hAC, 8'h00, 1'b1},
		'{8'h72, 4, 16'hFF99, 8'hAC, 8'h00, 1'b0}, '{8'h12, 2, 16'h8000, 8'h00, 8'h00, 1'b1},
		'{8'h12, 2, 16'h7FFF, 8'h00, 8'h00, 1'b0}, '{8'h12, 0, 16'hFB00, 8'h00, 8'h00, 1'b0},
		'{8'h12, 0, 16'hFFE0, 8'h00, 8'h00, 1'b0}, '{8'h12, 0, 16'h9000, 8'h00, 8'h00, 1'b1},
		'{8'h12, 1, 16'h9000, 8'h00, 8'h00, 1'b1}, '{8'h00, 2, 16'h8000, 8'h00, 8'h00, 1'b0},
		'{8'h00, 1, 16'hFF99, 8'h55, 8'h00, 1'b1}};
	wwt_watchdog i_wwt_watchdog (.i_sys_clk(sys_clk), .i_rstn(rstn), .i_lsclk(lsclk), .i_option_byte(opt),
		.i_mem_limit(16'h8000), .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_bit_op(bit_op), .i_fetch(fetch),
		.i_wdata(wdata), .o_rdata(rdata), .o_reset_req(req), .o_watchdog_reset_cause_flag(flag));
	wwt_cpu_model i_wwt_cpu_model (.i_sys_clk(sys_clk), .i_ls_run(ls_run), .i_rdata(rdata), .o_lsclk(lsclk),
		.o_addr(addr), .o_wr(wr), .o_rd(rd), .o_bit_op(bit_op), .o_fetch(fetch), .o_wdata(wdata));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
			err_total++;
		end
	endtask
	task automatic restart(input logic [7:0] o);
		@(posedge sys_clk);
		#1;
		rstn = 1'b0;
		opt = o;
		repeat (3) @(posedge sys_clk);
		#1;
		rstn = 1'b1;
		@(posedge sys_clk);
	endtask
	task automatic wait_req(input logic exp, input int bound);
		for (int n = 0; n < bound && req !== 1'b1; n++) @(posedge sys_clk);
		#1;
		check({7'h00, req}, {7'h00, exp}, "reset request");
		check({7'h00, flag}, {7'h00, exp}, "cause flag");
	endtask
	task automatic conclude();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// clock and sequence
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		rstn = 1'b0;
		ls_run = 1'b1;
		opt = 8'h00;
		foreach (rows[i]) begin
			restart(rows[i].opt);
			kind = (rows[i].op == 0) ? 2'h0 : (rows[i].op == 2) ? 2'h2 : 2'h1;
			if (rows[i].op == 4) i_wwt_cpu_model.access(2'h1, 16'hFF99, 8'hAC, 1'b0, rd_got);
			i_wwt_cpu_model.access(kind, rows[i].addr, rows[i].data, rows[i].op == 3, rd_got);
			if (rows[i].op == 0) check(rd_got, rows[i].rd, "read data");
			wait_req(rows[i].req, 40);
		end
		// refresh then overflow at 2^10 ticks, 100 percent window
		restart(8'h70);
		repeat (8000) @(posedge sys_clk);
		#1;
		check({7'h00, req}, 8'h00, "early overflow");
		i_wwt_cpu_model.access(2'h1, 16'hFF99, 8'hAC, 1'b0, rd_got);
		repeat (8000) @(posedge sys_clk);
		#1;
		check({7'h00, req}, 8'h00, "refresh ignored");
		wait_req(1'b1, 600);
		// half window, 2^11 overflow: late refresh accepted, then overflow
		restart(8'h32);
		i_wwt_cpu_model.access(2'h1, 16'hFF99, 8'hAC, 1'b0, rd_got);
		repeat (8400) @(posedge sys_clk);
		i_wwt_cpu_model.access(2'h1, 16'hFF99, 8'hAC, 1'b0, rd_got);
		repeat (16000) @(posedge sys_clk);
		#1;
		check({7'h00, req}, 8'h00, "open window refresh");
		wait_req(1'b1, 600);
		// wrong key while the slow clock is stopped
		restart(8'h12);
		#1;
		ls_run = 1'b0;
		repeat (4) @(posedge sys_clk);
		i_wwt_cpu_model.access(2'h1, 16'hFF99, 8'h55, 1'b0, rd_got);
		repeat (30) @(posedge sys_clk);
		#1;
		check({7'h00, req}, 8'h00, "reset not deferred");
		ls_run = 1'b1;
		wait_req(1'b1, 40);
		conclude();
	end
endmodule
